// >>> rtl/kpc_ctrl.sv
// Keypad command interpreter for installer programming mode, with an APB register port.
// Assumes keys arrive as one-cycle strobes synchronous to clk_sys_i.
`include "kpc_map.svh"

// Functional notes
// - Star plus pound within 30 s enters
// - Installer code then 8000 enters programming
// - Code defaults 5140, changed via field 00
// - Star 98 exits and locks code entry
// - Star 99 exits without lockout
// - Star field selects field for writing
// - Pound field shows field without change
// - Complete entry beeps thrice and advances
// - Star 91 selects partition for fields
// - Star 92 shows software revision
// - Star 93 enters menu mode
// - Star 94 moves to next page
// - Star 99 backs a page or exits
// - Higher page shows message with page
// - Each page has its valid field range
// - Invalid address shows address error
// - Out-of-range value blanks and is rejected
// - Global advance skips partition fields unless single
// - Partition advance returns to global page
// - Global field number leaves partition programming
// - Short entry waits for next star selection
// - Defaults enable keypads 00 and 01 only
// - Download setting disables local programming
module kpc_ctrl
  import kpc_pkg::*;
#(
  parameter int unsigned PWRUP_CYC = `KPC_PWRUP_S * `KPC_CLK_HZ,
  parameter int unsigned BEEP_GAP_CYC = `KPC_BEEP_GAP_MS * (`KPC_CLK_HZ / 1000)
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Keypad
  input wire kpc_key_t key_i,
  output kpc_disp_t disp_o,
  output logic beep_o,
  // Status
  output logic prog_mode_o,
  output logic menu_mode_o,
  output logic [31:0] keypad_en_o
);

  kpc_core_t c;
  kpc_core_t next_c;
  logic [15:0] gmem [0:399];
  logic [15:0] pmem [0:55];
  logic gwe;
  logic [8:0] gwa;
  logic pwe;
  logic [5:0] pwa;
  logic [15:0] wdat;

  function automatic logic [6:0] bin2(input logic [7:0] b);
    return 7'(b[7:4] * 7'd10) + 7'(b[3:0]);
  endfunction

  function automatic logic [8:0] gidx(input logic [1:0] pg, input logic [7:0] f);
    return 9'(pg * 9'd100) + 9'(bin2(f));
  endfunction

  function automatic logic [5:0] pidx(input logic [2:0] pt, input logic [7:0] f);
    return 6'(pt * 6'd7) + 6'(bin2(f) - bin2(`KPC_PF_FIRST));
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] f);
    if (f[3:0] == 4'h9) begin
      return {4'(f[7:4] + 4'h1), 4'h0};
    end
    return {f[7:4], 4'(f[3:0] + 4'h1)};
  endfunction

  function automatic logic is_pf(input logic [1:0] pg, input logic [7:0] f);
    return (pg == 2'h0) && (f >= `KPC_PF_FIRST) && (f <= `KPC_PF_LAST);
  endfunction

  function automatic logic f_ok(input logic [1:0] pg, input logic [7:0] f);
    logic ok;
    ok = 1'b0;
    if (f[3:0] <= 4'h9 && f[7:4] <= 4'h9) begin
      case (pg)
        2'h0: ok = f <= `KPC_P0_MAX;
        2'h1: ok = f >= `KPC_P1_MIN && f <= `KPC_P1_MAX;
        2'h2: ok = f <= `KPC_P2_MAX;
        default: ok = f <= `KPC_P3_MAX;
      endcase
    end
    return ok;
  endfunction

  function automatic kpc_disp_t mk_disp(input kpc_disp_kind_t k, input logic [1:0] pg,
                                        input logic [7:0] f, input logic [15:0] v);
    kpc_disp_t d;
    d.kind = k;
    d.higher_page_message = pg != 2'h0;
    d.page = pg;
    d.field = f;
    d.value = v;
    return d;
  endfunction

  logic key_ok;
  logic is_dig;
  logic [3:0] kd;
  logic [7:0] kf;
  logic [7:0] look_f;
  logic [15:0] look_val;
  logic [7:0] nf;
  logic [15:0] nb;
  logic [2:0] maxd;
  logic setup;
  logic access;
  logic dl_enter;
  logic dl_exit;

  assign kd = key_i.code;
  assign is_dig = kd <= 4'h9;
  assign key_ok = key_i.valid && c.kp_en[key_i.addr];
  assign kf = {c.addr_hi, kd};
  assign look_f = (c.st == ST_ADDR2) ? kf : c.field;
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign dl_enter = access && pwrite_i && paddr_i == `KPC_REG_CTRL
                    && pwdata_i[`KPC_CTRL_DL_ENTER];
  assign dl_exit = access && pwrite_i && paddr_i == `KPC_REG_CTRL
                   && pwdata_i[`KPC_CTRL_DL_EXIT];

  // Partition fields live in their own store, one block per partition.
  always_comb begin
    if (is_pf(c.page, look_f)) begin
      look_val = pmem[pidx(c.part_sel, look_f)];
    end else if (f_ok(c.page, look_f)) begin
      look_val = gmem[gidx(c.page, look_f)];
    end else begin
      look_val = 16'h0000;
    end
  end

  // Next field after a completed entry.
  always_comb begin
    nf = bcd_inc(c.field);
    if (c.part_mode) begin
      if (!is_pf(c.page, nf)) begin
        nf = 8'h00;
      end
    end else if (c.num_part != 3'h0 && is_pf(c.page, nf)) begin
      nf = bcd_inc(`KPC_PF_LAST);
    end
    if (!c.part_mode && !f_ok(c.page, nf)) begin
      nf = (c.page == 2'h1) ? `KPC_P1_MIN : 8'h00;
    end
  end

  assign nb = {c.dbuf[11:0], kd};
  assign maxd = (c.page == 2'h0 && c.field == `KPC_CODE_FIELD) ? 3'h4 : 3'h2;

  always_comb begin
    next_c = c;
    gwe = 1'b0;
    gwa = gidx(c.page, c.field);
    pwe = 1'b0;
    pwa = pidx(c.part_sel, c.field);
    wdat = nb;
    next_c.beep = 1'b0;
    if (c.pwr_cnt < 30'(PWRUP_CYC)) begin
      next_c.pwr_cnt = c.pwr_cnt + 30'h1;
    end
    if (c.beep_left != 2'h0) begin
      if (c.beep_gap == 21'h0) begin
        next_c.beep = 1'b1;
        next_c.beep_left = c.beep_left - 2'h1;
        next_c.beep_gap = 21'(BEEP_GAP_CYC - 1);
      end else begin
        next_c.beep_gap = c.beep_gap - 21'h1;
      end
    end
    if (key_ok && c.prog && (kd == `KPC_KEY_STAR || kd == `KPC_KEY_POUND)
        && (c.st == ST_CMD || c.st == ST_ADDR1 || c.st == ST_ADDR2
            || c.st == ST_DATA || (c.st == ST_BLANK && kd == `KPC_KEY_STAR))) begin
      next_c.st = ST_ADDR1;
      next_c.rd_mode = kd == `KPC_KEY_POUND;
    end else if (key_ok) begin
      case (c.st)
        ST_IDLE: begin
          next_c.seq = is_dig ? {c.seq[27:0], kd} : 32'h0;
          if (!c.local_dis && kd == `KPC_KEY_BOTH && c.pwr_cnt < 30'(PWRUP_CYC)) begin
            next_c.prog = 1'b1;
          end
          if (!c.local_dis && !c.lockout && is_dig
              && {c.seq[27:0], kd} == {c.inst_code, `KPC_ENTER_TAIL}) begin
            next_c.prog = 1'b1;
          end
        end
        ST_ADDR1: begin
          if (is_dig) begin
            next_c.addr_hi = kd;
            next_c.st = ST_ADDR2;
          end
        end
        ST_ADDR2: begin
          if (is_dig) begin
            next_c.st = ST_CMD;
            if (!c.rd_mode && kf > `KPC_P0_MAX) begin
              case (kf)
                `KPC_CMD_PART: begin
                  next_c.st = ST_PART;
                  next_c.disp = mk_disp(DSP_PART_ASK, c.page, kf, 16'h0);
                end
                `KPC_CMD_REV: begin
                  next_c.disp = mk_disp(DSP_REV, c.page, kf, `KPC_SW_REV);
                end
                `KPC_CMD_MENU: begin
                  next_c.st = ST_MENU;
                  next_c.disp = mk_disp(DSP_MENU, c.page, kf, 16'h0);
                end
                `KPC_CMD_NEXT: begin
                  if (c.page != 2'h3) begin
                    next_c.page = c.page + 2'h1;
                  end
                  next_c.disp = mk_disp(DSP_PROG, next_c.page, 8'h00, 16'h0);
                end
                `KPC_CMD_DEFAULTS: begin
                  next_c.st = ST_LOAD;
                  next_c.ld_cnt = 9'h0;
                end
                `KPC_CMD_LOCK: begin
                  next_c.prog = 1'b0;
                  next_c.lockout = 1'b1;
                  next_c.st = ST_IDLE;
                end
                `KPC_CMD_BACK: begin
                  if (c.page != 2'h0) begin
                    next_c.page = c.page - 2'h1;
                    next_c.disp = mk_disp(DSP_PROG, next_c.page, 8'h00, 16'h0);
                  end else begin
                    next_c.prog = 1'b0;
                    next_c.st = ST_IDLE;
                  end
                end
                default: begin
                  next_c.disp = mk_disp(DSP_ADDR_ERR, c.page, kf, 16'h0);
                end
              endcase
            end else if (f_ok(c.page, kf)) begin
              if (!is_pf(c.page, kf)) begin
                next_c.part_mode = 1'b0;
              end
              next_c.field = kf;
              next_c.disp = mk_disp(DSP_FIELD, c.page, kf, look_val);
              if (!c.rd_mode) begin
                next_c.st = ST_DATA;
                next_c.dcnt = 3'h0;
                next_c.dbuf = 16'h0;
              end
            end else begin
              next_c.disp = mk_disp(DSP_ADDR_ERR, c.page, kf, 16'h0);
            end
          end
        end
        ST_DATA: begin
          if (is_dig) begin
            next_c.dbuf = nb;
            next_c.dcnt = c.dcnt + 3'h1;
            next_c.disp = mk_disp(DSP_FIELD, c.page, c.field, nb);
            if (c.dcnt + 3'h1 == maxd) begin
              if (maxd == 3'h2 && nb[7:0] > `KPC_VAL_MAX) begin
                next_c.st = ST_BLANK;
                next_c.disp = mk_disp(DSP_BLANK, c.page, c.field, 16'h0);
              end else begin
                gwe = !is_pf(c.page, c.field);
                pwe = is_pf(c.page, c.field);
                if (c.page == 2'h0 && c.field == `KPC_CODE_FIELD) begin
                  next_c.inst_code = nb;
                end
                next_c.beep_left = `KPC_BEEPS;
                next_c.beep_gap = 21'h0;
                next_c.field = nf;
                next_c.dcnt = 3'h0;
                next_c.dbuf = 16'h0;
                if (c.part_mode && !is_pf(c.page, nf)) begin
                  next_c.part_mode = 1'b0;
                  next_c.page = 2'h0;
                end
                next_c.disp = mk_disp(DSP_FIELD, next_c.page, nf, 16'h0);
              end
            end
          end
        end
        ST_PART: begin
          next_c.st = ST_CMD;
          if (is_dig && kd != 4'h0 && kd <= {1'b0, c.num_part} + 4'h1) begin
            next_c.part_sel = 3'(kd - 4'h1);
            next_c.part_mode = 1'b1;
            next_c.page = 2'h0;
            next_c.disp = mk_disp(DSP_PROG, 2'h0, 8'h00, 16'h0);
          end else begin
            next_c.disp = mk_disp(DSP_ADDR_ERR, c.page, 8'h00, 16'h0);
          end
        end
        ST_MENU: begin
          if (kd == `KPC_KEY_POUND) begin
            next_c.st = ST_CMD;
          end
        end
        default: begin
        end
      endcase
    end
    // Defaults are written one word per cycle; keys are ignored meanwhile.
    if (c.st == ST_LOAD) begin
      gwe = 1'b1;
      gwa = c.ld_cnt;
      wdat = 16'h0;
      pwe = c.ld_cnt < 9'd56;
      pwa = c.ld_cnt[5:0];
      next_c.ld_cnt = c.ld_cnt + 9'h1;
      if (c.ld_cnt == `KPC_FIELDS - 9'h1) begin
        next_c.st = ST_CMD;
        next_c.inst_code = `KPC_DEF_CODE;
        next_c.kp_en = `KPC_DEF_KP_EN;
        next_c.page = 2'h0;
        next_c.part_mode = 1'b0;
        next_c.disp = mk_disp(DSP_PROG, 2'h0, 8'h00, 16'h0);
      end
    end
    if (!c.prog && next_c.prog || dl_enter && !c.prog) begin
      next_c.prog = 1'b1;
      next_c.st = ST_CMD;
      next_c.page = 2'h0;
      next_c.part_mode = 1'b0;
      next_c.seq = 32'h0;
      next_c.disp = mk_disp(DSP_PROG, 2'h0, 8'h00, 16'h0);
    end
    if (dl_exit && c.prog) begin
      next_c.prog = 1'b0;
      next_c.st = ST_IDLE;
    end
    if (c.prog && !next_c.prog) begin
      next_c.disp = mk_disp(DSP_BLANK, 2'h0, 8'h00, 16'h0);
      next_c.page = 2'h0;
    end
    // APB: read data and error are captured in the setup cycle.
    if (setup) begin
      next_c.perr = 1'b0;
      case (paddr_i)
        `KPC_REG_CTRL: next_c.prdata = {28'h0, c.num_part, c.local_dis};
        `KPC_REG_STAT: next_c.prdata = {20'h0, c.pwr_cnt < 30'(PWRUP_CYC),
                                        c.st == ST_MENU, c.part_mode, c.part_sel,
                                        c.page, 2'h0, c.lockout, c.prog};
        `KPC_REG_FADDR: next_c.prdata = {23'h0, c.faddr};
        `KPC_REG_FDATA: next_c.prdata = {16'h0, gmem[c.faddr]};
        default: begin
          next_c.prdata = 32'h0;
          next_c.perr = 1'b1;
        end
      endcase
    end
    if (access && pwrite_i) begin
      if (paddr_i == `KPC_REG_CTRL) begin
        next_c.local_dis = pwdata_i[`KPC_CTRL_LOCAL_DIS];
        next_c.num_part = pwdata_i[3:1];
      end
      if (paddr_i == `KPC_REG_FADDR && pwdata_i[8:0] < `KPC_FIELDS) begin
        next_c.faddr = pwdata_i[8:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      c <= '0;
      c.inst_code <= `KPC_DEF_CODE;
      c.kp_en <= `KPC_DEF_KP_EN;
    end else begin
      c <= next_c;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (gwe) begin
      gmem[gwa] <= wdat;
    end
    if (pwe) begin
      pmem[pwa] <= wdat;
    end
  end

  assign prdata_o = c.prdata;
  assign pready_o = access;
  assign pslverr_o = access && c.perr;
  assign disp_o = c.disp;
  assign beep_o = c.beep;
  assign prog_mode_o = c.prog;
  assign menu_mode_o = c.st == ST_MENU;
  assign keypad_en_o = c.kp_en;

endmodule

// >>> rtl/kpc_map.svh
// Offsets, field positions, reset values and timing figures of the keypad programming block.
// Assumes a 20 MHz system clock and an APB register port.
`ifndef KPC_MAP_SVH
`define KPC_MAP_SVH
`define KPC_CLK_HZ 20000000
`define KPC_PWRUP_S 30
`define KPC_BEEP_GAP_MS 100
`define KPC_BEEPS 2'h3
`define KPC_DEF_CODE 16'h5140
`define KPC_ENTER_TAIL 16'h8000
`define KPC_DEF_KP_EN 32'h0000_0003
// Arbitrary revision value.
`define KPC_SW_REV 16'h0001
`define KPC_KEY_STAR 4'ha
`define KPC_KEY_POUND 4'hb
`define KPC_KEY_BOTH 4'hc
`define KPC_CMD_PART 8'h91
`define KPC_CMD_REV 8'h92
`define KPC_CMD_MENU 8'h93
`define KPC_CMD_NEXT 8'h94
`define KPC_CMD_DEFAULTS 8'h97
`define KPC_CMD_LOCK 8'h98
`define KPC_CMD_BACK 8'h99
`define KPC_P0_MAX 8'h90
`define KPC_P1_MIN 8'h01
`define KPC_P1_MAX 8'h76
`define KPC_P2_MAX 8'h88
`define KPC_P3_MAX 8'h85
`define KPC_PF_FIRST 8'h09
`define KPC_PF_LAST 8'h15
`define KPC_CODE_FIELD 8'h00
`define KPC_VAL_MAX 8'h15
`define KPC_FIELDS 9'h190
`define KPC_REG_CTRL 12'h000
`define KPC_REG_STAT 12'h004
`define KPC_REG_FADDR 12'h008
`define KPC_REG_FDATA 12'h00c
`define KPC_CTRL_LOCAL_DIS 0
`define KPC_CTRL_DL_ENTER 4
`define KPC_CTRL_DL_EXIT 5
`endif

// >>> rtl/kpc_pkg.sv
// Types shared by the keypad programming block.
// Assumes kpc_map.svh holds the numeric constants.
package kpc_pkg;
  typedef enum logic [2:0] {
    DSP_BLANK, DSP_PROG, DSP_FIELD, DSP_ADDR_ERR, DSP_REV, DSP_PART_ASK, DSP_MENU
  } kpc_disp_kind_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ADDR1, ST_ADDR2, ST_DATA, ST_PART, ST_MENU, ST_BLANK, ST_LOAD
  } kpc_state_t;
  typedef struct packed {
    kpc_disp_kind_t kind;
    logic higher_page_message;
    logic [1:0] page;
    logic [7:0] field;
    logic [15:0] value;
  } kpc_disp_t;
  typedef struct packed {
    logic valid;
    logic [4:0] addr;
    logic [3:0] code;
  } kpc_key_t;
  typedef struct packed {
    kpc_state_t st;
    logic prog;
    logic lockout;
    logic [1:0] page;
    logic part_mode;
    logic [2:0] part_sel;
    logic rd_mode;
    logic [3:0] addr_hi;
    logic [7:0] field;
    logic [15:0] dbuf;
    logic [2:0] dcnt;
    logic [15:0] inst_code;
    logic [31:0] kp_en;
    logic [31:0] seq;
    kpc_disp_t disp;
    logic local_dis;
    logic [2:0] num_part;
    logic [8:0] faddr;
    logic [8:0] ld_cnt;
    logic [1:0] beep_left;
    logic [20:0] beep_gap;
    logic beep;
    logic [29:0] pwr_cnt;
    logic [31:0] prdata;
    logic perr;
  } kpc_core_t;
endpackage

// >>> sim/kpc_ctrl_assertions.sv
// Concurrent checks on the keypad programming block, bound to kpc_ctrl.
// Assumes keys come from enabled keypads as one-cycle strobes.
`include "kpc_map.svh"
module kpc_ctrl_assertions
  import kpc_pkg::*;
#(
  parameter int unsigned PWRUP_CYC = 100,
  parameter int unsigned BEEP_GAP_CYC = 4
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Keypad and status
  input wire kpc_key_t key_i,
  input wire kpc_disp_t disp_o,
  input wire logic beep_o,
  input wire logic prog_mode_o,
  input wire logic menu_mode_o,
  input wire logic [31:0] keypad_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] up_cnt;
  logic [31:0] next_up_cnt;
  logic [7:0] since_beep;
  logic [7:0] next_since_beep;
  always_comb begin
    next_up_cnt = (up_cnt == '1) ? up_cnt : up_cnt + 32'h1;
    next_since_beep = beep_o ? 8'h1 : ((since_beep == 8'hff) ? since_beep : since_beep + 8'h1);
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      up_cnt <= '0;
      since_beep <= 8'hff;
    end else begin
      up_cnt <= next_up_cnt;
      since_beep <= next_since_beep;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_key(logic [3:0] c);
    key_i.valid && key_i.code == c && keypad_en_o[key_i.addr];
  endsequence
  sequence s_cmd(logic [3:0] hi, logic [3:0] lo);
    (prog_mode_o && !menu_mode_o) ##0 s_key(`KPC_KEY_STAR) ##1 s_key(hi) ##1 s_key(lo);
  endsequence
  property p_ready; psel_i && penable_i |-> pready_o; endproperty
  property p_err_access; pslverr_o |-> psel_i && penable_i; endproperty
  property p_beep_gap;
    beep_o && since_beep < 8'(2 * BEEP_GAP_CYC) |-> since_beep == 8'(BEEP_GAP_CYC);
  endproperty
  property p_page_msg; disp_o.page != 2'h0 |-> disp_o.higher_page_message; endproperty
  property p_lock_exit; s_cmd(4'h9, 4'h8) |=> !prog_mode_o; endproperty
  property p_addr_err; s_cmd(4'h9, 4'h5) |=> disp_o.kind == DSP_ADDR_ERR; endproperty
  property p_rev;
    s_cmd(4'h9, 4'h2) |=> disp_o.kind == DSP_REV && disp_o.value == `KPC_SW_REV;
  endproperty
  property p_menu; s_cmd(4'h9, 4'h3) |=> menu_mode_o; endproperty
  property p_defaults; s_cmd(4'h9, 4'h7) |-> ##[1:600] keypad_en_o == `KPC_DEF_KP_EN; endproperty
  property p_pwr_in;
    (!prog_mode_o && up_cnt < 32'(PWRUP_CYC - 2)) ##0 s_key(`KPC_KEY_BOTH) |=> prog_mode_o;
  endproperty
  property p_pwr_out;
    (!prog_mode_o && up_cnt > 32'(PWRUP_CYC + 2)) ##0 s_key(`KPC_KEY_BOTH) |=> !prog_mode_o;
  endproperty
  a_ready: assert property (p_ready) else $error("pready missing in access");
  a_err_access: assert property (p_err_access) else $error("pslverr outside access");
  a_beep_gap: assert property (p_beep_gap) else $error("beep spacing wrong");
  a_page_msg: assert property (p_page_msg) else $error("page message missing");
  a_lock_exit: assert property (p_lock_exit) else $error("lock exit failed");
  a_addr_err: assert property (p_addr_err) else $error("address error not shown");
  a_rev: assert property (p_rev) else $error("revision not shown");
  a_menu: assert property (p_menu) else $error("menu not entered");
  a_defaults: assert property (p_defaults) else $error("keypad enables wrong");
  a_pwr_in: assert property (p_pwr_in) else $error("power-up entry failed");
  a_pwr_out: assert property (p_pwr_out) else $error("late power-up entry");
endmodule

bind kpc_ctrl kpc_ctrl_assertions #(
  .PWRUP_CYC(PWRUP_CYC),
  .BEEP_GAP_CYC(BEEP_GAP_CYC)
) i_kpc_chk (
  .clk_sys_i(clk_sys_i),
  .rst_i(rst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .key_i(key_i),
  .disp_o(disp_o),
  .beep_o(beep_o),
  .prog_mode_o(prog_mode_o),
  .menu_mode_o(menu_mode_o),
  .keypad_en_o(keypad_en_o)
);

// >>> sim/kpc_keypad_model.sv
// Installer keypad model: sends key strobes and counts beep pulses.
// Assumes the clock of the panel; keys of one call go out back to back.
module kpc_keypad_model
  import kpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Keypad side
  input wire logic beep_i,
  output kpc_key_t key_o,
  output logic [7:0] beep_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    key_o = '0;
  end
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      beep_cnt_o <= 8'h0;
    end else if (beep_i) begin
      beep_cnt_o <= beep_cnt_o + 8'h1;
    end
  end
  // Sends the n low nibbles of s, most significant first, from keypad address a.
  task automatic press(input logic [4:0] a, input logic [31:0] s, input int n);
    int i;
    for (i = n - 1; i >= 0; i--) begin
      @(posedge clk_sys_i);
      key_o <= {1'b1, a, s[4*i +: 4]};
    end
    @(posedge clk_sys_i);
    key_o.valid <= 1'b0;
    // One more edge, so that the answer to the last key has settled when we return.
    @(posedge clk_sys_i);
  endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench of the keypad programming block.
// Assumes a shortened power-up window and beep gap.
`include "kpc_map.svh"
module tb
  import kpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PWR = 2000;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  kpc_key_t key;
  kpc_disp_t disp;
  logic beep;
  logic prog;
  logic menu;
  logic [31:0] kp_en;
  logic [7:0] beeps;
  logic [7:0] b0;
  logic [31:0] rd;
  logic er;
  int mismatches = 0;
  int n_compared = 0;

  kpc_ctrl #(.PWRUP_CYC(PWR), .BEEP_GAP_CYC(4)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .key_i(key), .disp_o(disp), .beep_o(beep),
    .prog_mode_o(prog), .menu_mode_o(menu), .keypad_en_o(kp_en));
  kpc_keypad_model i_kp (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .beep_i(beep), .key_o(key), .beep_cnt_o(beeps));

  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) begin
      @(posedge clk_sys_i);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    check(kp_en, 32'h3);
    apb(1'b0, `KPC_REG_STAT, 32'h0);
    check(rd, 32'h800);
    apb(1'b0, 12'h010, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, `KPC_REG_CTRL, 32'h2);
    apb(1'b0, `KPC_REG_CTRL, 32'h0);
    check(rd, 32'h2);
    i_kp.press(5'h0, 32'hc, 1);
    check(32'(prog), 32'h1);
    i_kp.press(5'h0, 32'ha97, 3);
    repeat (450) @(posedge clk_sys_i);
    check(kp_en, `KPC_DEF_KP_EN);
    i_kp.press(5'h2, 32'ha92, 3);
    check(32'(disp.kind == DSP_REV), 32'h0);
    i_kp.press(5'h0, 32'ha92, 3);
    check(32'(disp.value), 32'(`KPC_SW_REV));
    b0 = beeps;
    i_kp.press(5'h0, 32'ha0312, 5);
    repeat (20) @(posedge clk_sys_i);
    check({24'h0, 8'(beeps - b0)}, 32'h3);
    check(32'(disp.field), 32'h04);
    i_kp.press(5'h0, 32'hb03, 3);
    check(32'(disp.value), 32'h12);
    apb(1'b1, `KPC_REG_FADDR, 32'h3);
    apb(1'b0, `KPC_REG_FDATA, 32'h0);
    check(rd, 32'h12);
    i_kp.press(5'h0, 32'ha0499, 5);
    check(32'(disp.kind), 32'(DSP_BLANK));
    b0 = beeps;
    i_kp.press(5'h0, 32'ha051, 4);
    repeat (20) @(posedge clk_sys_i);
    check({24'h0, 8'(beeps - b0)}, 32'h0);
    check(32'(disp.field), 32'h05);
    i_kp.press(5'h0, 32'ha0801, 5);
    check(32'(disp.field), 32'h16);
    i_kp.press(5'h0, 32'ha912, 4);
    apb(1'b0, `KPC_REG_STAT, 32'h0);
    check(32'(rd[9:6]), 32'h9);
    i_kp.press(5'h0, 32'ha1501, 5);
    check(32'(disp.field), 32'h00);
    i_kp.press(5'h0, 32'ha912, 4);
    i_kp.press(5'h0, 32'ha03, 3);
    apb(1'b0, `KPC_REG_STAT, 32'h0);
    check(32'(rd[9]), 32'h0);
    check(32'(disp.field), 32'h03);
    i_kp.press(5'h0, 32'ha95, 3);
    check(32'(disp.kind), 32'(DSP_ADDR_ERR));
    i_kp.press(5'h0, 32'ha94, 3);
    check(32'(disp.page), 32'h1);
    check(32'(disp.higher_page_message), 32'h1);
    i_kp.press(5'h0, 32'ha00, 3);
    check(32'(disp.kind), 32'(DSP_ADDR_ERR));
    i_kp.press(5'h0, 32'ha99, 3);
    check({29'h0, disp.page, prog}, 32'h1);
    i_kp.press(5'h0, 32'ha93, 3);
    check(32'(menu), 32'h1);
    i_kp.press(5'h0, 32'hb, 1);
    check(32'(menu), 32'h0);
    i_kp.press(5'h0, 32'ha001234, 7);
    repeat (20) @(posedge clk_sys_i);
    i_kp.press(5'h0, 32'ha98, 3);
    apb(1'b0, `KPC_REG_STAT, 32'h0);
    check({30'h0, rd[1], prog}, 32'h2);
    i_kp.press(5'h0, 32'h12348000, 8);
    check(32'(prog), 32'h0);
    i_kp.press(5'h0, 32'hc, 1);
    check(32'(prog), 32'h1);
    i_kp.press(5'h0, 32'ha99, 3);
    check(32'(prog), 32'h0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    i_kp.press(5'h0, 32'h51408000, 8);
    check(32'(prog), 32'h1);
    i_kp.press(5'h0, 32'ha99, 3);
    i_kp.press(5'h0, 32'h51408000, 8);
    check(32'(prog), 32'h1);
    i_kp.press(5'h0, 32'ha99, 3);
    apb(1'b1, `KPC_REG_CTRL, 32'h1);
    i_kp.press(5'h0, 32'h51408000, 8);
    check(32'(prog), 32'h0);
    apb(1'b1, `KPC_REG_CTRL, 32'h11);
    @(posedge clk_sys_i);
    check(32'(prog), 32'h1);
    apb(1'b1, `KPC_REG_CTRL, 32'h21);
    @(posedge clk_sys_i);
    check(32'(prog), 32'h0);
    apb(1'b1, `KPC_REG_CTRL, 32'h0);
    repeat (PWR + 100) @(posedge clk_sys_i);
    i_kp.press(5'h0, 32'hc, 1);
    check(32'(prog), 32'h0);
    summarize();
  end
endmodule
